// ---- rtl/l2pc_consts.svh ----
// Constants for the cache data RAM parity checker.
// Assumes inclusion by the package and design modules by bare name.
`ifndef L2PC_CONSTS_SVH
`define L2PC_CONSTS_SVH
`define L2PC_DATA_WIDTH 256
`define L2PC_PAR_WIDTH 32
`define L2PC_LANE_WIDTH 8
`define L2PC_AUX_PAR_EN_BIT 21
`define L2PC_AUX_PAR_EN_RESET 1'b0
`define L2PC_LAT_LSB 4
`define L2PC_LAT_MSB 6
`define L2PC_LAT_WIDTH 3
`define L2PC_LAT_NONE 3'h0
`define L2PC_MASK_RESET 1'b0
`endif

// ---- rtl/l2pc_pkg.sv ----
// Types for the cache data RAM parity checker.
// Assumes l2pc_consts.svh is on the include path.
`include "l2pc_consts.svh"
package l2pc_pkg;
   typedef enum logic [1:0]
   {
      L2PC_IDLE = 2'b00,
      L2PC_WAIT = 2'b01,
      L2PC_CHECK = 2'b10
   } l2pc_state_type;
   typedef logic [`L2PC_PAR_WIDTH-1:0] l2pc_par_type;
endpackage

// ---- rtl/l2pc_parity_gen.sv ----
// Per-byte even parity generator over the 256-bit data RAM word.
// Assumes combinational use by the checker top.
`timescale 1ns/1ps
`include "l2pc_consts.svh"
module l2pc_parity_gen
   import l2pc_pkg::*;
(
   input wire logic [`L2PC_DATA_WIDTH-1:0] data_word,
   output l2pc_par_type par_bits
);
   genvar lane;
   generate
      for (lane = 0; lane < `L2PC_PAR_WIDTH; lane = lane + 1)
      begin : g_lane
         // One parity bit covers one byte lane
         assign par_bits[lane] = ^data_word[lane*`L2PC_LANE_WIDTH +: `L2PC_LANE_WIDTH];
      end
   endgenerate
endmodule

// ---- rtl/l2pc_parity_check.sv ----
// Data RAM parity checker for a level-2 cache controller.
// Assumes RAM arrays return read data latency cycles after read_strobe.
// What this block does
// [R01] Enabled: check 256-bit word against 32 parity bits
// [R02] Mismatch sets raw parity status, and masked status only when mask set
// [R03] Checking only when enable bit 21 set
// [R04] Enable bit resets to zero
// [R05] Three-bit read latency field, zero adds none
// [R06] Compare only once data is stable
// [R07] Software programs latency minimum plus one
// [R08] Masked status is raw AND mask, drives interrupt
`timescale 1ns/1ps
`include "l2pc_consts.svh"
module l2pc_parity_check
   import l2pc_pkg::*;
(
   input wire logic mclk,
   input wire logic reset,
   input wire logic aux_ctrl_write,
   input wire logic [31:0] aux_ctrl_wdata,
   input wire logic lat_ctrl_write,
   input wire logic [31:0] lat_ctrl_wdata,
   input wire logic par_mask_write,
   input wire logic par_mask_wdata,
   input wire logic par_status_clear,
   input wire logic read_strobe,
   input wire logic [`L2PC_DATA_WIDTH-1:0] data_ram_read_word,
   input wire l2pc_par_type parity_ram_read_bits,
   output logic parity_enable,
   output logic [`L2PC_LAT_WIDTH-1:0] read_latency,
   output logic parity_mask,
   output logic parity_raw_status,
   output logic parity_masked_status,
   output logic parity_irq,
   output logic check_busy
);
   logic par_en_reg;
   logic [`L2PC_LAT_WIDTH-1:0] lat_reg;
   logic mask_reg;
   logic raw_reg;
   l2pc_state_type state_reg;
   logic [`L2PC_LAT_WIDTH-1:0] count_reg;
   logic check_now;
   logic mismatch;
   l2pc_par_type computed_par;
   l2pc_par_type lane_err;
   logic raw_next;
   logic mask_next;
   logic masked_reg;

   l2pc_parity_gen u_gen
   (
      .data_word(data_ram_read_word),
      .par_bits(computed_par)
   );

   // Parity enable held by software, default off
   always_ff @(posedge mclk)
   begin
      if (reset)
         par_en_reg <= `L2PC_AUX_PAR_EN_RESET; // [R04]
      else if (aux_ctrl_write)
         par_en_reg <= aux_ctrl_wdata[`L2PC_AUX_PAR_EN_BIT]; // [R03]
   end

   // Latency only sampled from its three-bit field
   always_ff @(posedge mclk)
   begin
      if (reset)
         lat_reg <= `L2PC_LAT_NONE;
      else if (lat_ctrl_write)
         lat_reg <= lat_ctrl_wdata[`L2PC_LAT_MSB:`L2PC_LAT_LSB]; // [R05]
   end

   always_ff @(posedge mclk)
   begin
      if (reset)
         mask_reg <= `L2PC_MASK_RESET;
      else if (par_mask_write)
         mask_reg <= par_mask_wdata;
   end

   // Accepts a read only while enabled
   function automatic logic read_taken(input logic strobe, input logic enable);
      return strobe && enable;
   endfunction

   // Zero latency goes straight to the compare cycle
   function automatic logic no_wait(input logic [`L2PC_LAT_WIDTH-1:0] lat);
      return lat == `L2PC_LAT_NONE;
   endfunction

   // Sequencer: wait the full latency, then compare in one cycle only.
   // Comparing a cycle early would see unsettled RAM outputs.
   always_ff @(posedge mclk)
   begin
      if (reset)
         state_reg <= L2PC_IDLE;
      else
      begin
         case (state_reg)
            L2PC_IDLE:
            begin
               if (read_taken(read_strobe, par_en_reg)) // [R03]
               begin
                  if (no_wait(lat_reg))
                     state_reg <= L2PC_CHECK; // [R05]
                  else
                     state_reg <= L2PC_WAIT;
               end
            end
            L2PC_WAIT:
            begin
               if (count_reg == 3'h1)
                  state_reg <= L2PC_CHECK; // [R06]
            end
            L2PC_CHECK:
            begin
               // Back-to-back reads restart the wait here
               if (read_taken(read_strobe, par_en_reg))
               begin
                  if (no_wait(lat_reg))
                     state_reg <= L2PC_CHECK;
                  else
                     state_reg <= L2PC_WAIT;
               end
               else
                  state_reg <= L2PC_IDLE;
            end
            default:
               state_reg <= L2PC_IDLE;
         endcase
      end
   end

   // Wait counter: loaded on an accepted read, counts down while waiting
   always_ff @(posedge mclk)
   begin
      if (reset)
         count_reg <= `L2PC_LAT_NONE;
      else
      begin
         case (state_reg)
            L2PC_IDLE, L2PC_CHECK:
            begin
               if (read_taken(read_strobe, par_en_reg))
                  count_reg <= lat_reg; // [R05]
            end
            L2PC_WAIT:
               count_reg <= count_reg - 3'h1;
            default:
               count_reg <= `L2PC_LAT_NONE;
         endcase
      end
   end

   // Reads issued during a wait are not checked; limitation of one tracker
   assign check_now = (state_reg == L2PC_CHECK) && par_en_reg; // [R06] [R03]

   // Lane-wise compare keeps the failing byte visible when probing
   genvar lane;
   generate
      for (lane = 0; lane < `L2PC_PAR_WIDTH; lane = lane + 1)
      begin : g_cmp
         assign lane_err[lane] = computed_par[lane] ^ parity_ram_read_bits[lane]; // [R01]
      end
   endgenerate
   assign mismatch = |lane_err; // [R01]

   // Next raw status; a new error wins over a clear in the same cycle
   always_comb
   begin
      raw_next = raw_reg;
      if (check_now && mismatch)
         raw_next = 1'b1; // [R02]
      else if (par_status_clear)
         raw_next = 1'b0;
   end

   // Next mask, so the masked flop moves in step with the raw flop
   always_comb
   begin
      mask_next = mask_reg;
      if (par_mask_write)
         mask_next = par_mask_wdata;
   end

   // Sticky raw status
   always_ff @(posedge mclk)
   begin
      if (reset)
         raw_reg <= 1'b0;
      else
         raw_reg <= raw_next; // [R02]
   end

   // Masked status from its own flop rather than a gate on the output
   always_ff @(posedge mclk)
   begin
      if (reset)
         masked_reg <= 1'b0;
      else
         masked_reg <= raw_next & mask_next; // [R08] [R02]
   end

   assign parity_enable = par_en_reg;
   assign read_latency = lat_reg;
   assign parity_mask = mask_reg;
   assign parity_raw_status = raw_reg;
   assign parity_masked_status = masked_reg; // [R08] [R02]
   assign parity_irq = masked_reg; // [R08]
   assign check_busy = state_reg != L2PC_IDLE;
endmodule

// ---- testbench/l2pc_props.sv ----
// Port checker for the data RAM parity checker.
// Assumes a bind onto l2pc_parity_check.
`timescale 1ns/1ps
module l2pc_props
(
   input wire logic mclk,
   input wire logic reset,
   input wire logic aux_ctrl_write,
   input wire logic [31:0] aux_ctrl_wdata,
   input wire logic par_status_clear,
   input wire logic read_strobe,
   input wire logic parity_enable,
   input wire logic [2:0] read_latency,
   input wire logic parity_mask,
   input wire logic parity_raw_status,
   input wire logic parity_masked_status,
   input wire logic parity_irq,
   input wire logic check_busy
);
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   en_load_a: assert property (aux_ctrl_write
      |=> parity_enable == $past(aux_ctrl_wdata[21])) else $error("enable load");
   mask_and_a: assert property (
      parity_masked_status == (parity_raw_status & parity_mask)) else $error("mask");
   irq_drive_a: assert property (parity_irq == parity_masked_status)
      else $error("irq");
   raw_hold_a: assert property (parity_raw_status && !par_status_clear
      |=> parity_raw_status) else $error("raw lost");
   en_reset_a: assert property ($past(reset) |-> !parity_enable)
      else $error("enable reset");
   off_quiet_a: assert property (!parity_enable && !check_busy && !parity_raw_status
      |=> !parity_raw_status) else $error("raw while off");
   start_busy_a: assert property (read_strobe && parity_enable && !check_busy
      |=> check_busy) else $error("no start");
   wait_len_a: assert property (read_strobe && parity_enable && !check_busy
      && read_latency == 3'h2 |=> check_busy[*3] ##1 !check_busy) else $error("wait");
   cover property (parity_irq);
   cover property (read_strobe && parity_enable && read_latency == 3'h7);
   cover property (parity_raw_status && !parity_mask);
endmodule

// ---- testbench/l2pc_ram_model.sv ----
// Data and parity RAM model; read word valid only in the check cycle.
// Assumes latency comes from the checker's read_latency output.
`timescale 1ns/1ps
module l2pc_ram_model
   import l2pc_pkg::*;
(
   input wire logic mclk,
   input wire logic read_strobe,
   input wire logic [2:0] lat,
   input wire logic bad,
   output logic [255:0] word,
   output l2pc_par_type par
);
   int cnt = -1;
   logic [31:0] v = 32'h0;
   l2pc_par_type p;
   always @(posedge mclk)
   begin
      cnt <= read_strobe ? int'(lat) : cnt - 1;
      if (read_strobe) v <= $urandom;
   end
   // Wrong parity outside the window exposes an early compare
   always_comb
   begin
      for (int i = 0; i < 32; i++) p[i] = ^v[8 * (i % 4) +: 8];
      word = (cnt == 0) ? {8{v}} : ~{8{v}};
      par = (cnt == 0) ? p ^ 32'(bad) : ~p;
   end
endmodule

// ---- testbench/testbench.sv ----
// Self-checking bench for the data RAM parity checker.
// Assumes the RAM model and checker are compiled first.
`timescale 1ns/1ps
module testbench;
   import l2pc_pkg::*;
   logic mclk = 0, reset = 1, aux_ctrl_write = 0, lat_ctrl_write = 0, par_mask_write = 0;
   logic par_mask_wdata = 0, par_status_clear = 0, read_strobe = 0, bad = 0;
   logic [31:0] aux_ctrl_wdata = 0, lat_ctrl_wdata = 0;
   logic [255:0] data_ram_read_word;
   l2pc_par_type parity_ram_read_bits;
   logic parity_enable, parity_mask, parity_raw_status, parity_masked_status;
   logic parity_irq, check_busy;
   logic [2:0] read_latency;
   int n_errors = 0, checks_done = 0;
   always #12.5 mclk = ~mclk;
   l2pc_parity_check l2pc_parity_check_i (.mclk, .reset, .aux_ctrl_write, .aux_ctrl_wdata,
      .lat_ctrl_write, .lat_ctrl_wdata, .par_mask_write, .par_mask_wdata, .par_status_clear,
      .read_strobe, .data_ram_read_word, .parity_ram_read_bits, .parity_enable,
      .read_latency, .parity_mask, .parity_raw_status, .parity_masked_status,
      .parity_irq, .check_busy);
   l2pc_ram_model l2pc_ram_model_i (.mclk, .read_strobe, .lat(read_latency), .bad,
      .word(data_ram_read_word), .par(parity_ram_read_bits));
   task chk(input logic [2:0] s, input logic [2:0] e);
      checks_done++;
      if (s !== e)
      begin
         n_errors++;
         $display("BAD %0t got %h want %h", $time, s, e);
      end
   endtask
   function automatic logic exp_raw(input logic en, input logic b);
      return en && b;
   endfunction
   task run(input logic en, input logic [2:0] l, input logic b, input logic m);
      aux_ctrl_wdata = 32'(en) << 21;
      lat_ctrl_wdata = 32'(l) << 4;
      par_mask_wdata = m;
      {aux_ctrl_write, lat_ctrl_write, par_mask_write} = 3'h7;
      @(posedge mclk) #2;
      {aux_ctrl_write, lat_ctrl_write, par_mask_write} = 3'h0;
      {read_strobe, bad} = {1'b1, b};
      chk(read_latency, l);
      @(posedge mclk) #2;
      read_strobe = 0;
      chk(check_busy, en);
      chk(parity_mask, m);
      repeat (l + 2) @(posedge mclk);
      #2 chk(parity_raw_status, exp_raw(en, b));
      chk(parity_irq, exp_raw(en, b) & m);
      chk(parity_masked_status, exp_raw(en, b) & m);
      chk(check_busy, 3'h0);
      par_status_clear = 1;
      @(posedge mclk) #2 par_status_clear = 0;
      chk(parity_raw_status, 3'h0);
   endtask
   task wrap_up;
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial
   begin
      void'($urandom(32'h8FB49856));
      repeat (2) @(posedge mclk);
      #2 reset = 0;
      chk(parity_enable, 3'h0);
      for (int i = 0; i < 12; i++)
         run(i != 1, i < 8 ? 3'(i) : 3'($urandom), i == 1 || $urandom % 2, 1'($urandom));
      wrap_up;
   end
endmodule
bind l2pc_parity_check l2pc_props l2pc_props_i (.mclk, .reset, .aux_ctrl_write,
   .aux_ctrl_wdata, .par_status_clear, .read_strobe, .parity_enable, .read_latency,
   .parity_mask, .parity_raw_status, .parity_masked_status, .parity_irq, .check_busy);
